// >>> dadc_map.svh
// register offsets, field positions, reset values and timing counts
`ifndef DADC_MAP_SVH
`define DADC_MAP_SVH
// register offsets
`define DADC_OFS_CHAN_SEL     9'h005
`define DADC_OFS_POWER_MODE   9'h008
`define DADC_OFS_CLOCK_CTRL   9'h009
`define DADC_OFS_CLOCK_DIV    9'h00b
`define DADC_OFS_TEST_MODE    9'h00d
`define DADC_OFS_SELF_TEST    9'h00e
`define DADC_OFS_OUTPUT_MODE  9'h014
`define DADC_OFS_DCO_DELAY    9'h017
`define DADC_OFS_SIG_LOW      9'h024
`define DADC_OFS_SIG_HIGH     9'h025
`define DADC_OFS_SYNC_CTRL    9'h100
// field positions
`define DADC_BIT_CHAN_A       0
`define DADC_BIT_CHAN_B       1
`define DADC_BIT_POWER_DOWN   0
`define DADC_BIT_STANDBY      1
`define DADC_BIT_DCS_ENABLE   0
`define DADC_BIT_PN_LONG_RST  4
`define DADC_BIT_PN_SHORT_RST 5
`define DADC_BIT_ST_ENABLE    0
`define DADC_BIT_ST_RESTART   2
`define DADC_BIT_TRISTATE     4
`define DADC_BIT_INTERLEAVE   5
`define DADC_BIT_DCO_INVERT   7
`define DADC_BIT_SYNC_ENABLE  0
`define DADC_BIT_SYNC_ONESHOT 1
`define DADC_BIT_SYNC_ARMED   2
// reset values
`define DADC_RST_CHAN_SEL     8'h03
`define DADC_RST_CLOCK_CTRL   8'h01
`define DADC_RST_ZERO         8'h00
`define DADC_PN_LONG_SEED     23'h7fffff
`define DADC_PN_SHORT_SEED    9'h1ff
`define DADC_ST_SEED          16'hace1
// timing counts in converter cycles
`define DADC_PIPE_LATENCY     12
`define DADC_SELF_TEST_CYCLES 512
`endif

// >>> dadc_pkg.sv
// types shared by the dual converter back end
package dadc_pkg;
	// output coding selected by register or strap
	typedef enum logic [1:0] {
		FMT_OFFSET_BINARY,
		FMT_TWOS_COMPLEMENT,
		FMT_GRAY_CODE,
		FMT_RESERVED
	} dadc_fmt_e;
	// output test patterns
	typedef enum logic [3:0] {
		TP_OFF, TP_MIDSCALE, TP_POS_FULL, TP_NEG_FULL,
		TP_CHECKER, TP_PN_LONG, TP_PN_SHORT, TP_ONE_ZERO
	} dadc_tp_e;
	// self-test sequencer
	typedef enum logic {ST_IDLE, ST_RUN} dadc_st_e;
	// one sample with its over-range flag
	typedef struct packed {
		logic        ovr;
		logic [13:0] word;
	} dadc_smp_s;
	// a sample pair, channel b above channel a
	typedef struct packed {
		dadc_smp_s b;
		dadc_smp_s a;
	} dadc_pair_s;
endpackage

// >>> dadc_back_end.sv
// digital back end of a dual 14-bit converter
//
// Contract
// - divider resync on first sync only or on every sync
// - sync pin passes a two-stage synchroniser on the sample clock
// - power-down by bit or pin; outputs high impedance; pin low resumes
// - standby keeps reference powered for faster wake-up
// - reset default: separate output bus per channel
// - interleaved mode sends both channels on a; b high impedance
// - strap: format pin low offset binary, high twos; register adds gray
// - strap: stabiliser pin low disables, high enables stabiliser
// - tristate pin low enables data and data clocks, high floats all
// - bit 4 of output mode floats each channel independently
// - samples appear twelve converter cycles after capture
// - data valid at data clock rising edge, opposite if inverted
// - delay register adds data clock delay; interleaved a rise, b fall
// - offset binary codes, twos inverts msb, over-range flag passes
// - self-test feeds pseudorandom data into datapath for 512 cycles
// - signature of selected channel, channel a when both selected
// - outputs stay connected while the self-test runs
// - self-test start continues or restarts sequence per bit 2
// - output test mode replaces core data before formatting
// - pseudorandom test generators held at seed while reset bit set
// - patterns need the clock; analog input ignored in test modes
// - sync control bits 1 and 2 pick every or first-after-write
// - accepted sync resets divider; ratio one to eight
`timescale 1ns/1ps
`include "dadc_map.svh"
module dadc_back_end #(
	parameter int LATENCY   = `DADC_PIPE_LATENCY,
	parameter int ST_CYCLES = `DADC_SELF_TEST_CYCLES
) (
	// clock and reset
	input  wire logic                 i_clk,
	input  wire logic                 i_rstn,
	// converter core samples, same clock
	input  wire dadc_pkg::dadc_pair_s i_core,
	// device pins, asynchronous
	input  wire logic                 i_sync,
	input  wire logic                 i_power_down_pin,
	input  wire logic                 i_output_tristate_ctrl,
	input  wire logic                 i_format_select_pin,
	input  wire logic                 i_stabilizer_select_pin,
	input  wire logic                 i_strap_mode,
	// register port from the control interface
	input  wire logic                 i_reg_wr,
	input  wire logic [8:0]           i_reg_addr,
	input  wire logic [7:0]           i_reg_wdata,
	output logic      [7:0]           o_reg_rdata,
	// output buses
	output dadc_pkg::dadc_smp_s       o_data_a,
	output dadc_pkg::dadc_smp_s       o_data_b,
	output logic                      o_data_a_oe,
	output logic                      o_data_b_oe,
	output logic                      o_data_clock_out_a,
	output logic                      o_data_clock_out_b,
	output logic                      o_data_clock_out_a_oe,
	output logic                      o_data_clock_out_b_oe,
	// analog control
	output logic                      o_power_down,
	output logic                      o_reference_on,
	output logic                      o_duty_cycle_stabilizer,
	output logic                      o_converter_tick
);
	// elaboration checks on the parameters
	if (LATENCY < 2 || LATENCY > 64) begin : g_bad_latency
		$error("LATENCY out of range");
	end
	if (ST_CYCLES < 2 || ST_CYCLES > 65535) begin : g_bad_cycles
		$error("ST_CYCLES out of range");
	end

	////////////////////////////////////////////////////////////////////
	// functions

	// output coding of an offset binary word
	function automatic logic [13:0] fmt_word(input logic [13:0] w,
			input dadc_pkg::dadc_fmt_e f);
		case (f)
			dadc_pkg::FMT_TWOS_COMPLEMENT: fmt_word = {~w[13], w[12:0]};
			dadc_pkg::FMT_GRAY_CODE:       fmt_word = w ^ {1'b0, w[13:1]};
			default:                       fmt_word = w;
		endcase
	endfunction

	// one step of a fibonacci shift register
	function automatic logic [22:0] pn_step(input logic [22:0] s,
			input logic fb);
		pn_step = {s[21:0], fb};
	endfunction

	////////////////////////////////////////////////////////////////////
	// pin synchronisers

	logic [4:0] pin_s1_ff;
	logic [4:0] pin_s2_ff;
	logic       sync_d_ff;
	// two flops per pin, first stage read only by the second
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			pin_s1_ff <= 5'h00;
			pin_s2_ff <= 5'h00;
			sync_d_ff <= 1'b0;
		end else begin
			pin_s1_ff <= {i_strap_mode, i_stabilizer_select_pin,
				i_format_select_pin, i_output_tristate_ctrl, i_sync};
			pin_s2_ff <= pin_s1_ff;
			sync_d_ff <= pin_s2_ff[0];
		end
	end
	logic sync_pin, tri_pin, fmt_pin, dcs_pin, strap;
	assign sync_pin = pin_s2_ff[0];
	assign tri_pin  = pin_s2_ff[1];
	assign fmt_pin  = pin_s2_ff[2];
	assign dcs_pin  = pin_s2_ff[3];
	assign strap    = pin_s2_ff[4];

	logic power_down_pin_s1_ff, power_down_pin_s2_ff;
	// power-down pin synchroniser
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			power_down_pin_s1_ff <= 1'b0;
			power_down_pin_s2_ff <= 1'b0;
		end else begin
			power_down_pin_s1_ff <= i_power_down_pin;
			power_down_pin_s2_ff <= power_down_pin_s1_ff;
		end
	end

	////////////////////////////////////////////////////////////////////
	// register file

	logic [7:0] chan_sel_ff, power_ff, clk_ctrl_ff, div_ff, test_ff;
	logic [7:0] st_ctrl_ff, out_mode_ff, dco_dly_ff, sync_ctrl_ff;
	logic       tri_a_ff, tri_b_ff;
	logic       sync_accept, st_done;
	logic [15:0] sig_ff;
	logic       wr_chan, wr_st, wr_sync, wr_out;
	assign wr_chan = i_reg_wr && i_reg_addr == `DADC_OFS_CHAN_SEL;
	assign wr_st   = i_reg_wr && i_reg_addr == `DADC_OFS_SELF_TEST;
	assign wr_sync = i_reg_wr && i_reg_addr == `DADC_OFS_SYNC_CTRL;
	assign wr_out  = i_reg_wr && i_reg_addr == `DADC_OFS_OUTPUT_MODE;

	// plain control registers
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			chan_sel_ff <= `DADC_RST_CHAN_SEL;
			power_ff    <= `DADC_RST_ZERO;
			clk_ctrl_ff <= `DADC_RST_CLOCK_CTRL;
			div_ff      <= `DADC_RST_ZERO;
			test_ff     <= `DADC_RST_ZERO;
			out_mode_ff <= `DADC_RST_ZERO;
			dco_dly_ff  <= `DADC_RST_ZERO;
		end else if (i_reg_wr) begin
			case (i_reg_addr)
				`DADC_OFS_CHAN_SEL:    chan_sel_ff <= i_reg_wdata;
				`DADC_OFS_POWER_MODE:  power_ff    <= i_reg_wdata;
				`DADC_OFS_CLOCK_CTRL:  clk_ctrl_ff <= i_reg_wdata;
				`DADC_OFS_CLOCK_DIV:   div_ff      <= i_reg_wdata;
				`DADC_OFS_TEST_MODE:   test_ff     <= i_reg_wdata;
				`DADC_OFS_OUTPUT_MODE: out_mode_ff <= i_reg_wdata;
				`DADC_OFS_DCO_DELAY:   dco_dly_ff  <= i_reg_wdata;
				default: ;
			endcase
		end
	end

	// per-channel three-state bits, written for selected channels
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			tri_a_ff <= 1'b0;
			tri_b_ff <= 1'b0;
		end else if (wr_out) begin
			if (chan_sel_ff[`DADC_BIT_CHAN_A])
				tri_a_ff <= i_reg_wdata[`DADC_BIT_TRISTATE];
			if (chan_sel_ff[`DADC_BIT_CHAN_B])
				tri_b_ff <= i_reg_wdata[`DADC_BIT_TRISTATE];
		end
	end

	// self-test control, enable clears itself when the run ends
	always_ff @(posedge i_clk) begin
		if (!i_rstn)
			st_ctrl_ff <= `DADC_RST_ZERO;
		else if (wr_st)
			st_ctrl_ff <= i_reg_wdata;
		else if (st_done)
			st_ctrl_ff[`DADC_BIT_ST_ENABLE] <= 1'b0;
	end

	// sync control, armed bit set by write and spent by an accepted sync when one-shot bit 1 is set
	always_ff @(posedge i_clk) begin
		if (!i_rstn)
			sync_ctrl_ff <= `DADC_RST_ZERO;
		else if (wr_sync)
			sync_ctrl_ff <= i_reg_wdata | (8'h01 << `DADC_BIT_SYNC_ARMED);
		else if (sync_accept && sync_ctrl_ff[`DADC_BIT_SYNC_ONESHOT])
			sync_ctrl_ff[`DADC_BIT_SYNC_ARMED] <= 1'b0;
	end

	// read-back, tristate shows channel a when selected, else b
	logic [7:0] nxt_rdata;
	always_comb begin
		case (i_reg_addr)
			`DADC_OFS_CHAN_SEL:    nxt_rdata = chan_sel_ff;
			`DADC_OFS_POWER_MODE:  nxt_rdata = power_ff;
			`DADC_OFS_CLOCK_CTRL:  nxt_rdata = clk_ctrl_ff;
			`DADC_OFS_CLOCK_DIV:   nxt_rdata = div_ff;
			`DADC_OFS_TEST_MODE:   nxt_rdata = test_ff;
			`DADC_OFS_SELF_TEST:   nxt_rdata = st_ctrl_ff;
			`DADC_OFS_OUTPUT_MODE: begin
				nxt_rdata = out_mode_ff;
				nxt_rdata[`DADC_BIT_TRISTATE] =
					chan_sel_ff[`DADC_BIT_CHAN_A] ? tri_a_ff : tri_b_ff;
			end
			`DADC_OFS_DCO_DELAY:   nxt_rdata = dco_dly_ff;
			`DADC_OFS_SIG_LOW:     nxt_rdata = sig_ff[7:0];
			`DADC_OFS_SIG_HIGH:    nxt_rdata = sig_ff[15:8];
			`DADC_OFS_SYNC_CTRL:   nxt_rdata = sync_ctrl_ff;
			default:               nxt_rdata = 8'h00;
		endcase
	end
	always_ff @(posedge i_clk) begin
		if (!i_rstn)
			o_reg_rdata <= 8'h00;
		else
			o_reg_rdata <= nxt_rdata;
	end

	////////////////////////////////////////////////////////////////////
	// clock divider and sync

	logic [2:0] div_cnt_ff;
	logic       tick;
	assign sync_accept = sync_pin && !sync_d_ff
		&& sync_ctrl_ff[`DADC_BIT_SYNC_ENABLE]
		&& (!sync_ctrl_ff[`DADC_BIT_SYNC_ONESHOT]
			|| sync_ctrl_ff[`DADC_BIT_SYNC_ARMED]);
	assign tick = div_cnt_ff == 3'h0;
	// ratio is field plus one, one to eight
	always_ff @(posedge i_clk) begin
		if (!i_rstn)
			div_cnt_ff <= 3'h0;
		else if (sync_accept)
			div_cnt_ff <= 3'h0;
		else if (tick)
			div_cnt_ff <= div_ff[2:0];
		else
			div_cnt_ff <= div_cnt_ff - 3'h1;
	end
	always_ff @(posedge i_clk) begin
		if (!i_rstn)
			o_converter_tick <= 1'b0;
		else
			o_converter_tick <= tick;
	end

	////////////////////////////////////////////////////////////////////
	// power and mode control

	logic pd, standby;
	assign pd      = power_ff[`DADC_BIT_POWER_DOWN] || power_down_pin_s2_ff;
	assign standby = power_ff[`DADC_BIT_STANDBY];
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			o_power_down            <= 1'b0;
			o_reference_on          <= 1'b1;
			o_duty_cycle_stabilizer <= 1'b1;
		end else begin
			o_power_down   <= pd || standby;
			o_reference_on <= !pd;
			o_duty_cycle_stabilizer <= strap ? dcs_pin
				: clk_ctrl_ff[`DADC_BIT_DCS_ENABLE];
		end
	end

	dadc_pkg::dadc_fmt_e fmt;
	assign fmt = strap ? (fmt_pin ? dadc_pkg::FMT_TWOS_COMPLEMENT
		: dadc_pkg::FMT_OFFSET_BINARY)
		: dadc_pkg::dadc_fmt_e'(out_mode_ff[1:0]);

	////////////////////////////////////////////////////////////////////
	// test pattern generators

	logic [22:0] pn_long_ff;
	logic [8:0]  pn_short_ff;
	logic        tog_ff;
	// generators run on every converter cycle, held at seed in reset
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			pn_long_ff  <= `DADC_PN_LONG_SEED;
			pn_short_ff <= `DADC_PN_SHORT_SEED;
			tog_ff      <= 1'b0;
		end else begin
			if (test_ff[`DADC_BIT_PN_LONG_RST])
				pn_long_ff <= `DADC_PN_LONG_SEED;
			else if (tick)
				pn_long_ff <= pn_step(pn_long_ff,
					pn_long_ff[22] ^ pn_long_ff[17]);
			if (test_ff[`DADC_BIT_PN_SHORT_RST])
				pn_short_ff <= `DADC_PN_SHORT_SEED;
			else if (tick)
				pn_short_ff <= {pn_short_ff[7:0],
					pn_short_ff[8] ^ pn_short_ff[4]};
			if (tick)
				tog_ff <= !tog_ff;
		end
	end

	dadc_pkg::dadc_tp_e tp;
	logic [13:0]        tp_word;
	assign tp = dadc_pkg::dadc_tp_e'(test_ff[3:0]);
	// pattern in offset binary, formatted later
	always_comb begin
		case (tp)
			dadc_pkg::TP_MIDSCALE: tp_word = 14'h2000;
			dadc_pkg::TP_POS_FULL: tp_word = 14'h3fff;
			dadc_pkg::TP_NEG_FULL: tp_word = 14'h0000;
			dadc_pkg::TP_CHECKER:  tp_word = tog_ff ? 14'h2aaa : 14'h1555;
			dadc_pkg::TP_PN_LONG:  tp_word = pn_long_ff[13:0];
			dadc_pkg::TP_PN_SHORT: tp_word = {pn_short_ff, pn_short_ff[4:0]};
			dadc_pkg::TP_ONE_ZERO: tp_word = {14{tog_ff}};
			default:               tp_word = 14'h0000;
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// self-test

	dadc_pkg::dadc_st_e st_state_ff;
	logic [15:0] st_cnt_ff, st_lfsr_ff, misr_ff;
	logic        st_start;
	assign st_start = st_state_ff == dadc_pkg::ST_IDLE
		&& st_ctrl_ff[`DADC_BIT_ST_ENABLE];
	assign st_done = st_state_ff == dadc_pkg::ST_RUN && tick
		&& st_cnt_ff == 16'(ST_CYCLES - 1);

	// sequencer, counts converter cycles then stops
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			st_state_ff <= dadc_pkg::ST_IDLE;
			st_cnt_ff   <= 16'h0000;
		end else begin
			case (st_state_ff)
				dadc_pkg::ST_IDLE: if (st_start) begin
					st_state_ff <= dadc_pkg::ST_RUN;
					st_cnt_ff   <= 16'h0000;
				end
				dadc_pkg::ST_RUN: if (st_done)
					st_state_ff <= dadc_pkg::ST_IDLE;
				else if (tick)
					st_cnt_ff <= st_cnt_ff + 16'h0001;
				default: st_state_ff <= dadc_pkg::ST_IDLE;
			endcase
		end
	end

	logic st_run;
	assign st_run = st_state_ff == dadc_pkg::ST_RUN;
	// source continues across runs unless restart bit is set
	always_ff @(posedge i_clk) begin
		if (!i_rstn)
			st_lfsr_ff <= `DADC_ST_SEED;
		else if (st_start && st_ctrl_ff[`DADC_BIT_ST_RESTART])
			st_lfsr_ff <= `DADC_ST_SEED;
		else if (st_run && tick)
			st_lfsr_ff <= {st_lfsr_ff[14:0], st_lfsr_ff[15]
				^ st_lfsr_ff[14] ^ st_lfsr_ff[12] ^ st_lfsr_ff[3]};
	end

	////////////////////////////////////////////////////////////////////
	// datapath: source select, pipeline, formatting

	dadc_pkg::dadc_pair_s src;
	logic st_a, st_b;
	assign st_a = st_run && chan_sel_ff[`DADC_BIT_CHAN_A];
	assign st_b = st_run && chan_sel_ff[`DADC_BIT_CHAN_B];
	// test modes cut the core off, so analog input is ignored
	always_comb begin
		src = i_core;
		if (tp != dadc_pkg::TP_OFF) begin
			src.a = '{ovr: 1'b0, word: tp_word};
			src.b = '{ovr: 1'b0, word: tp_word};
		end
		if (st_a)
			src.a = '{ovr: 1'b0, word: st_lfsr_ff[13:0]};
		if (st_b)
			src.b = '{ovr: 1'b0, word: st_lfsr_ff[13:0]};
	end

	// signature compacts the formatted word of the chosen channel
	dadc_pkg::dadc_smp_s sig_src;
	assign sig_src = chan_sel_ff[`DADC_BIT_CHAN_A] ? src.a : src.b;
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			misr_ff <= 16'h0000;
			sig_ff  <= 16'h0000;
		end else begin
			if (st_start)
				misr_ff <= 16'h0000;
			else if (st_run && tick)
				misr_ff <= {misr_ff[14:0], misr_ff[15] ^ misr_ff[13]}
					^ {2'b00, fmt_word(sig_src.word, fmt)};
			if (st_done)
				sig_ff <= misr_ff;
		end
	end

	// latency stages ahead of the output register
	dadc_pkg::dadc_pair_s pipe_ff [LATENCY];
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			for (int i = 0; i < LATENCY; i++)
				pipe_ff[i] <= '0;
		end else if (tick) begin
			pipe_ff[0] <= src;
			for (int i = 1; i < LATENCY; i++)
				pipe_ff[i] <= pipe_ff[i-1];
		end
	end

	dadc_pkg::dadc_pair_s last;
	logic                 ilv, phase_ff;
	assign last = pipe_ff[LATENCY-1];
	assign ilv  = out_mode_ff[`DADC_BIT_INTERLEAVE];

	// interleaved words alternate a then b on the a bus
	always_ff @(posedge i_clk) begin
		if (!i_rstn)
			phase_ff <= 1'b0;
		else if (!ilv)
			phase_ff <= 1'b0;
		else if (tick)
			phase_ff <= !phase_ff;
	end

	// output register, updated after each converter edge
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			o_data_a <= '0;
			o_data_b <= '0;
		end else if (tick) begin
			if (ilv && phase_ff)
				o_data_a <= '{ovr: last.b.ovr,
					word: fmt_word(last.b.word, fmt)};
			else
				o_data_a <= '{ovr: last.a.ovr,
					word: fmt_word(last.a.word, fmt)};
			o_data_b <= '{ovr: last.b.ovr,
				word: fmt_word(last.b.word, fmt)};
		end
	end

	////////////////////////////////////////////////////////////////////
	// data clocks and output enables

	logic       dco_base_ff;
	logic [7:0] dco_sr_ff;
	logic       dco_pol;
	// base clock toggles once per word, at each word update
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			dco_base_ff <= 1'b0;
			dco_sr_ff   <= 8'h00;
		end else begin
			if (tick)
				dco_base_ff <= !dco_base_ff;
			dco_sr_ff <= {dco_sr_ff[6:0], dco_base_ff};
		end
	end
	// delay taps the shift line, polarity flips the valid edge
	assign dco_pol = dco_sr_ff[dco_dly_ff[2:0]]
		^ dco_dly_ff[`DADC_BIT_DCO_INVERT];

	logic quiet;
	assign quiet = tri_pin || pd || standby;
	// outputs stay live during self-test, only pins and bits float them
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			o_data_clock_out_a    <= 1'b0;
			o_data_clock_out_b    <= 1'b0;
			o_data_a_oe           <= 1'b0;
			o_data_b_oe           <= 1'b0;
			o_data_clock_out_a_oe <= 1'b0;
			o_data_clock_out_b_oe <= 1'b0;
		end else begin
			o_data_clock_out_a    <= dco_pol;
			o_data_clock_out_b    <= dco_pol;
			o_data_a_oe           <= !quiet && !tri_a_ff;
			o_data_clock_out_a_oe <= !quiet && !tri_a_ff;
			o_data_b_oe           <= !quiet && !tri_b_ff && !ilv;
			o_data_clock_out_b_oe <= !quiet && !tri_b_ff && !ilv;
		end
	end

endmodule // dadc_back_end

// >>> dadc_back_end_assertions.sv
// concurrent checks on the converter back end ports
`timescale 1ns/1ps
module dadc_back_end_assertions (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rstn,
	// pins and register port
	input wire logic i_power_down_pin,
	input wire logic i_output_tristate_ctrl,
	input wire logic i_stabilizer_select_pin,
	input wire logic i_strap_mode,
	input wire logic i_reg_wr,
	input wire logic [8:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic [7:0] o_reg_rdata,
	// outputs watched
	input wire logic o_data_a_oe,
	input wire logic o_data_b_oe,
	input wire logic o_data_clock_out_a_oe,
	input wire logic o_data_clock_out_b_oe,
	input wire logic o_power_down,
	input wire logic o_reference_on,
	input wire logic o_duty_cycle_stabilizer
);
	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rstn);
	AST_TRI_DATA: assert property (i_output_tristate_ctrl[*4] |->
		!o_data_a_oe && !o_data_b_oe) else $error("data bus driven");
	AST_TRI_DCLK: assert property (i_output_tristate_ctrl[*4] |->
		!o_data_clock_out_a_oe && !o_data_clock_out_b_oe)
		else $error("data clock driven");
	AST_POWER_DOWN_PIN_PIN: assert property (i_power_down_pin[*4] |->
		o_power_down && !o_reference_on && !o_data_a_oe)
		else $error("power-down pin ignored");
	AST_STANDBY: assert property (i_reg_wr && i_reg_addr == 9'h008
		&& i_reg_wdata == 8'h02 |-> ##3 o_power_down && o_reference_on)
		else $error("standby state wrong");
	AST_ILV_B_OFF: assert property (i_reg_wr && i_reg_addr == 9'h014
		&& i_reg_wdata[5] |-> ##2 !o_data_b_oe) else $error("bus b on");
	AST_TRI_BIT: assert property (i_reg_wr && i_reg_addr == 9'h014
		&& i_reg_wdata[4] |-> ##2 !o_data_a_oe && !o_data_clock_out_a_oe)
		else $error("tristate bit ignored");
	AST_DELAY_RB: assert property ((i_reg_wr && i_reg_addr == 9'h017)
		##1 (!i_reg_wr && i_reg_addr == 9'h017)
		|=> o_reg_rdata == $past(i_reg_wdata, 2)) else $error("delay lost");
	AST_SYNC_ARM: assert property ((i_reg_wr && i_reg_addr == 9'h100)
		##1 (!i_reg_wr && i_reg_addr == 9'h100) |=> o_reg_rdata[2])
		else $error("sync not armed");
	AST_STRAP_DCS: assert property ((i_strap_mode && $stable(i_strap_mode)
		&& $stable(i_stabilizer_select_pin))[*4]
		|-> o_duty_cycle_stabilizer == i_stabilizer_select_pin)
		else $error("stabiliser strap ignored");
endmodule // dadc_back_end_assertions
bind dadc_back_end dadc_back_end_assertions u_chk (.i_clk, .i_rstn,
	.i_power_down_pin, .i_output_tristate_ctrl, .i_stabilizer_select_pin,
	.i_strap_mode, .i_reg_wr, .i_reg_addr, .i_reg_wdata, .o_reg_rdata,
	.o_data_a_oe, .o_data_b_oe, .o_data_clock_out_a_oe,
	.o_data_clock_out_b_oe, .o_power_down, .o_reference_on,
	.o_duty_cycle_stabilizer);

// >>> dadc_capture_model.sv
// far-side capture register clocked by the data clock
`timescale 1ns/1ps
module dadc_capture_model (
	// data clock and bus
	input  wire logic                i_dclk,
	input  wire logic                i_oe,
	input  wire dadc_pkg::dadc_smp_s i_data,
	// captured word and count
	output dadc_pkg::dadc_smp_s      o_word,
	output int                       o_count
);
	////////////////////////////////////////////////////////////////////////
	// capture at the rising data clock while the bus is driven
	initial o_count = 0;
	always @(posedge i_dclk) begin
		if (i_oe) begin
			o_word <= i_data;
			o_count <= o_count + 1;
		end
	end
endmodule // dadc_capture_model

// >>> dadc_back_end_tb.sv
// self-checking testbench for the converter back end
`timescale 1ns/1ps
module dadc_back_end_tb;
	localparam int ST = 16;
	logic i_clk, i_rstn, i_sync, i_power_down_pin, i_output_tristate_ctrl;
	logic i_format_select_pin, i_stabilizer_select_pin, i_strap_mode;
	logic i_reg_wr, o_data_a_oe, o_data_b_oe, o_power_down, o_reference_on;
	logic o_data_clock_out_a, o_data_clock_out_b, o_duty_cycle_stabilizer;
	logic o_data_clock_out_a_oe, o_data_clock_out_b_oe, o_converter_tick;
	logic [8:0] i_reg_addr;
	logic [7:0] i_reg_wdata, o_reg_rdata, v;
	logic [15:0] s1, s2;
	dadc_pkg::dadc_pair_s i_core;
	dadc_pkg::dadc_smp_s o_data_a, o_data_b, cap_word;
	int n_fail, n_checks, cap_count, k0, k1;
	////////////////////////////////////////////////////////////////////////
	dadc_back_end #(.ST_CYCLES(ST)) DUT (.i_clk, .i_rstn, .i_core, .i_sync,
		.i_power_down_pin, .i_output_tristate_ctrl, .i_format_select_pin,
		.i_stabilizer_select_pin, .i_strap_mode, .i_reg_wr, .i_reg_addr,
		.i_reg_wdata, .o_reg_rdata, .o_data_a, .o_data_b, .o_data_a_oe,
		.o_data_b_oe, .o_data_clock_out_a, .o_data_clock_out_b,
		.o_data_clock_out_a_oe, .o_data_clock_out_b_oe, .o_power_down,
		.o_reference_on, .o_duty_cycle_stabilizer, .o_converter_tick);
	dadc_capture_model u_cap (.i_dclk(o_data_clock_out_a),
		.i_oe(o_data_a_oe), .i_data(o_data_a), .o_word(cap_word),
		.o_count(cap_count));
	// 40 mhz sample clock
	initial i_clk = 1'b0;
	always #12.5 i_clk = ~i_clk;
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge i_clk);
	endtask
	task automatic wr(input logic [8:0] a, input logic [7:0] d);
		i_reg_wr = 1'b1;
		i_reg_addr = a;
		i_reg_wdata = d;
		cyc(1);
		i_reg_wr = 1'b0;
		cyc(1);
	endtask
	task automatic rd(input logic [8:0] a, output logic [7:0] d);
		i_reg_addr = a;
		cyc(1);
		d = o_reg_rdata;
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic t_data;
		logic [13:0] w, e;
		i_core = {15'h0000, 15'h2000};
		cyc(12);
		chk(o_data_a, 15'h0000);
		cyc(1);
		chk(o_data_a, 15'h2000);
		for (int f = 0; f < 3; f++) begin
			wr(9'h014, 8'(f));
			for (int k = 0; k < 3; k++) begin
				w = (k == 0) ? 14'h0000 : (k == 1) ? 14'h2000 : 14'h3fff;
				e = (f == 1) ? w ^ 14'h2000 : (f == 2) ? w ^ (w >> 1) : w;
				i_core = {1'b1, w, 1'b0, w};
				cyc(16);
				chk(o_data_a, {1'b0, e});
				chk(o_data_b, {1'b1, e});
				chk(cap_word, {1'b0, e});
			end
		end
		chk(cap_count > 9, 1);
		wr(9'h014, 8'h00);
	endtask
	task automatic t_tmode;
		i_core = {15'h7fff, 15'h5555};
		for (int m = 1; m < 4; m++) begin
			wr(9'h00d, 8'(m));
			cyc(16);
			chk(o_data_a, m == 1 ? 15'h2000 : m == 2 ? 15'h3fff : 0);
		end
		wr(9'h00d, 8'h15);
		cyc(16);
		s1 = o_data_a;
		cyc(3);
		chk(o_data_a, s1);
		wr(9'h00d, 8'h05);
		cyc(16);
		chk(o_data_a !== s1[14:0], 1);
		wr(9'h00d, 8'h00);
	endtask
	task automatic t_pins;
		i_core = {15'h0111, 15'h0222};
		wr(9'h014, 8'h20);
		cyc(16);
		chk(o_data_b_oe, 0);
		s1 = o_data_a.word;
		cyc(1);
		chk(s1 ^ o_data_a.word, 16'h0333);
		wr(9'h014, 8'h10);
		cyc(2);
		chk({o_data_a_oe, o_data_clock_out_a_oe}, 0);
		wr(9'h014, 8'h00);
		i_output_tristate_ctrl = 1'b1;
		cyc(4);
		chk({o_data_a_oe, o_data_b_oe, o_data_clock_out_b_oe}, 0);
		i_output_tristate_ctrl = 1'b0;
		i_power_down_pin = 1'b1;
		cyc(4);
		chk({o_power_down, o_reference_on, o_data_a_oe}, 3'b100);
		i_power_down_pin = 1'b0;
		cyc(4);
		chk({o_power_down, o_reference_on, o_data_a_oe}, 3'b011);
		wr(9'h008, 8'h02);
		cyc(3);
		chk({o_power_down, o_reference_on}, 2'b11);
		wr(9'h008, 8'h00);
		i_strap_mode = 1'b1;
		i_format_select_pin = 1'b1;
		i_core = {15'h0000, 15'h2000};
		cyc(16);
		chk({o_data_a, o_duty_cycle_stabilizer}, 0);
		i_strap_mode = 1'b0;
	endtask
	task automatic run_st(input logic [7:0] c, output logic [15:0] s);
		int n;
		logic mv;
		wr(9'h00e, c);
		s = o_data_a;
		mv = 1'b0;
		n = 0;
		rd(9'h00e, v);
		while (o_reg_rdata[0] !== 1'b0 && n < 200) begin
			cyc(1);
			n++;
			mv |= (o_data_a !== s[14:0]);
		end
		chk(n >= ST - 2 && n <= ST + 14, 1);
		chk(mv, 1);
		rd(9'h024, s[7:0]);
		rd(9'h025, s[15:8]);
	endtask
	task automatic sync_at(input int p, output int k);
		cyc(p);
		i_sync = 1'b1;
		cyc(2);
		i_sync = 1'b0;
		cyc(8);
		k = 0;
		while (o_converter_tick !== 1'b1 && k < 8) begin
			cyc(1);
			k++;
		end
	endtask
	////////////////////////////////////////////////////////////////////////
	// watchdog sized well past the expected run
	initial begin
		repeat (6000) @(posedge i_clk);
		n_fail++;
		print_verdict();
	end
	// main sequence
	initial begin
		{i_rstn, i_sync, i_power_down_pin, i_output_tristate_ctrl} = '0;
		{i_format_select_pin, i_stabilizer_select_pin, i_strap_mode} = '0;
		{i_reg_wr, i_reg_addr, i_reg_wdata, i_core} = '0;
		n_fail = 0;
		n_checks = 0;
		cyc(3);
		i_rstn = 1'b1;
		cyc(2);
		chk({o_data_a_oe, o_data_b_oe, o_reference_on}, 3'b111);
		wr(9'h024, 8'h5a);
		foreach (v[i]) begin
			rd(i < 6 ? 9'h00d + 9'(i) : 9'h01e + 9'(i), s1[7:0]);
			chk(s1[7:0], 0);
		end
		$display("reset test done");
		t_data();
		$display("data test done");
		t_tmode();
		$display("pattern test done");
		t_pins();
		$display("pin test done");
		i_core = {15'h0555, 15'h1234};
		run_st(8'h05, s1);
		run_st(8'h05, s2);
		chk(s2, s1);
		run_st(8'h01, s2);
		chk(s1 !== s2, 1);
		$display("self-test done");
		wr(9'h00b, 8'h03);
		sync_at(0, k0);
		s2 = 0;
		repeat (16) begin
			v[0] = o_data_clock_out_a;
			cyc(1);
			s2 += 16'(o_data_clock_out_a !== v[0]);
			chk(o_data_clock_out_b, o_data_clock_out_a);
		end
		chk(s2, 4);
		wr(9'h100, 8'h01);
		sync_at(0, k0);
		sync_at(1, k1);
		chk(k1, k0);
		wr(9'h100, 8'h03);
		sync_at(2, k1);
		chk(k1, k0);
		rd(9'h100, v);
		chk(v[2], 0);
		sync_at(1, k1);
		chk(k1 != k0, 1);
		wr(9'h017, 8'h83);
		rd(9'h017, v);
		chk(v, 8'h83);
		$display("sync test done");
		print_verdict();
	end
endmodule // dadc_back_end_tb
